// file: core/irq_route_pkg.sv
package irq_route_pkg;

  // Register map of the interrupt routing and indication block.
  localparam logic [7:0] ADDR_OT_ROUTE    = 8'h6D;
  localparam logic [7:0] ADDR_ROUTE_A     = 8'h70;
  localparam logic [7:0] ADDR_ROUTE_B     = 8'h71;
  localparam logic [7:0] ADDR_STYLE       = 8'h72;

  // Field positions inside the byte registers.
  localparam int unsigned ROUTE_HI_LSB    = 4;
  localparam int unsigned ROUTE_LO_LSB    = 0;
  localparam int unsigned STYLE_ONE_LSB   = 6;
  localparam int unsigned STYLE_TWO_LSB   = 4;
  localparam int unsigned STYLE_THREE_LSB = 2;
  localparam int unsigned STYLE_FOUR_LSB  = 0;

  localparam logic [2:0] ROUTE_RESET      = 3'h0;
  localparam logic [7:0] RDATA_RESET      = 8'h00;

  localparam int unsigned NUM_PINS        = 4;
  localparam int unsigned NUM_SRCS        = 5;

  // Timing: printed times and the clock rate, then derived cycle counts.
  localparam int unsigned CLK_KHZ         = 250000;
  localparam int unsigned PULSE_MS        = 2;
  localparam int unsigned PERIOD_MS       = 4;
  localparam int unsigned PULSE_CYC       = PULSE_MS * CLK_KHZ;
  localparam int unsigned PERIOD_CYC      = PERIOD_MS * CLK_KHZ;
  localparam int unsigned CNT_W           = 20;

  typedef enum logic [1:0] {
    STYLE_ONE_PULSE,
    STYLE_REPEAT,
    STYLE_LATCH,
    STYLE_LIVE
  } style_t;

endpackage

// file: core/dsp_irq_router.sv
// Overview of operation
// - DSP source one has a 3-bit route in bits 6-4 at 0x70: 0 unused, 1-4 pick a pin, 5-7 reserved.
// - DSP source two has the same 3-bit route in bits 2-0 at 0x70.
// - DSP source three has the same 3-bit route in bits 6-4 at 0x71.
// - DSP source four has the same 3-bit route in bits 2-0 at 0x71.
// - Each pin has a 2-bit style at 0x72: pin one bits 7-6, two 5-4, three 3-2, four 1-0.
// - Style zero gives one 2 ms high pulse per interrupt; an interrupt arriving while a pulse runs gets none.
// - Style one repeats 2 ms high pulses every 4 ms until both status registers are read.
// - Style two holds the pin high from the interrupt until both status registers are read.
// - Style three drives the pin high while its combined interrupt condition is present, one clock later.
// - The over-temperature source has its own 3-bit route with the same encoding.
module dsp_irq_router
  import irq_route_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES  = irq_route_pkg::PULSE_CYC,
  parameter int unsigned PERIOD_CYCLES = irq_route_pkg::PERIOD_CYC
) (
  input  wire logic       i_clk,            // Main clock, 250 MHz.
  input  wire logic       i_rst,            // Asynchronous reset, active high.
  input  wire logic [3:0] i_dsp_irq,        // DSP interrupt sources one to four.
  input  wire logic       i_overtemp,       // Die over-temperature event.
  input  wire logic       i_sticky_cleared, // Pulse: both status registers read.
  input  wire logic [7:0] i_reg_addr,       // Register address.
  input  wire logic       i_reg_wr,         // Register write strobe.
  input  wire logic [7:0] i_reg_wdata,      // Register write data.
  input  wire logic       i_reg_rd,         // Register read strobe.
  output logic      [7:0] o_reg_rdata,      // Read data, valid after a read.
  output logic            o_irq_out_one,    // Interrupt pin one.
  output logic            o_irq_out_two,    // Interrupt pin two.
  output logic            o_irq_out_three,  // Interrupt pin three.
  output logic            o_irq_out_four    // Interrupt pin four.
);
  import irq_route_pkg::*;

  logic   [2:0]          dsp_src_one_route_q;
  logic   [2:0]          dsp_src_two_route_q;
  logic   [2:0]          dsp_src_three_route_q;
  logic   [2:0]          dsp_src_four_route_q;
  logic   [2:0]          overtemp_route_q;
  style_t                pin_one_signal_style_q;
  style_t                pin_two_signal_style_q;
  style_t                pin_three_signal_style_q;
  style_t                pin_four_signal_style_q;
  logic   [7:0]          rdata_q;
  logic   [2:0]          route [NUM_SRCS];
  style_t                style [NUM_PINS];
  logic   [NUM_SRCS-1:0] src;
  logic   [NUM_PINS-1:0] cond;
  logic   [NUM_PINS-1:0] cond_q;
  logic   [NUM_PINS-1:0] evt;
  logic   [NUM_PINS-1:0] latch_q;
  logic   [NUM_PINS-1:0] busy_q;
  logic   [NUM_PINS-1:0] out_d;
  logic   [NUM_PINS-1:0] out_q;
  logic   [CNT_W-1:0]    cnt_q [NUM_PINS];

  localparam logic [CNT_W-1:0] PULSE_LAST  = CNT_W'(PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYCLES - 1);
  localparam logic [CNT_W-1:0] PULSE_LEN   = CNT_W'(PULSE_CYCLES);

  // True when a route code selects the given pin; codes 0 and 5-7 select none.
  function automatic logic routes_to(input logic [2:0] r, input int unsigned pin);
    return r == 3'(pin + 1);
  endfunction

  assign route[0] = dsp_src_one_route_q;
  assign route[1] = dsp_src_two_route_q;
  assign route[2] = dsp_src_three_route_q;
  assign route[3] = dsp_src_four_route_q;
  assign route[4] = overtemp_route_q;
  assign style[0] = pin_one_signal_style_q;
  assign style[1] = pin_two_signal_style_q;
  assign style[2] = pin_three_signal_style_q;
  assign style[3] = pin_four_signal_style_q;
  assign src      = {i_overtemp, i_dsp_irq};

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dsp_src_one_route_q   <= ROUTE_RESET;
      dsp_src_two_route_q   <= ROUTE_RESET;
      dsp_src_three_route_q <= ROUTE_RESET;
      dsp_src_four_route_q  <= ROUTE_RESET;
      overtemp_route_q      <= ROUTE_RESET;
    end else if (i_reg_wr) begin
      if (i_reg_addr == ADDR_ROUTE_A) begin
        dsp_src_one_route_q <= i_reg_wdata[ROUTE_HI_LSB +: 3];
        dsp_src_two_route_q <= i_reg_wdata[ROUTE_LO_LSB +: 3];
      end else if (i_reg_addr == ADDR_ROUTE_B) begin
        dsp_src_three_route_q <= i_reg_wdata[ROUTE_HI_LSB +: 3];
        dsp_src_four_route_q  <= i_reg_wdata[ROUTE_LO_LSB +: 3];
      end else if (i_reg_addr == ADDR_OT_ROUTE) begin
        overtemp_route_q <= i_reg_wdata[ROUTE_LO_LSB +: 3];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_one_signal_style_q   <= STYLE_ONE_PULSE;
      pin_two_signal_style_q   <= STYLE_ONE_PULSE;
      pin_three_signal_style_q <= STYLE_ONE_PULSE;
      pin_four_signal_style_q  <= STYLE_ONE_PULSE;
    end else if (i_reg_wr && i_reg_addr == ADDR_STYLE) begin
      pin_one_signal_style_q   <= style_t'(i_reg_wdata[STYLE_ONE_LSB +: 2]);
      pin_two_signal_style_q   <= style_t'(i_reg_wdata[STYLE_TWO_LSB +: 2]);
      pin_three_signal_style_q <= style_t'(i_reg_wdata[STYLE_THREE_LSB +: 2]);
      pin_four_signal_style_q  <= style_t'(i_reg_wdata[STYLE_FOUR_LSB +: 2]);
    end
  end

  // Read data is captured on the read strobe and held; reserved bits and unmapped addresses read zero.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= RDATA_RESET;
    end else if (i_reg_rd) begin
      if (i_reg_addr == ADDR_ROUTE_A) begin
        rdata_q <= {1'b0, dsp_src_one_route_q, 1'b0, dsp_src_two_route_q};
      end else if (i_reg_addr == ADDR_ROUTE_B) begin
        rdata_q <= {1'b0, dsp_src_three_route_q, 1'b0, dsp_src_four_route_q};
      end else if (i_reg_addr == ADDR_OT_ROUTE) begin
        rdata_q <= {5'h00, overtemp_route_q};
      end else if (i_reg_addr == ADDR_STYLE) begin
        rdata_q <= {pin_one_signal_style_q, pin_two_signal_style_q,
                    pin_three_signal_style_q, pin_four_signal_style_q};
      end else begin
        rdata_q <= RDATA_RESET;
      end
    end
  end

  always_comb begin
    cond = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      for (int s = 0; s < NUM_SRCS; s++) begin
        if (src[s] && routes_to(route[s], p)) begin
          cond[p] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cond_q <= '0;
    end else begin
      cond_q <= cond;
    end
  end

  assign evt = cond & ~cond_q;

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    // Latch holds until status clear; a new event wins over the clear.
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        latch_q[p] <= 1'b0;
      end else if (evt[p]) begin
        latch_q[p] <= 1'b1;
      end else if (i_sticky_cleared) begin
        latch_q[p] <= 1'b0;
      end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        busy_q[p] <= 1'b0;
        cnt_q[p]  <= '0;
      end else begin
        case (style[p])
          STYLE_ONE_PULSE: begin
            if (evt[p] && !busy_q[p]) begin
              busy_q[p] <= 1'b1;
              cnt_q[p]  <= '0;
            end else if (busy_q[p] && cnt_q[p] == PULSE_LAST) begin
              busy_q[p] <= 1'b0;
              cnt_q[p]  <= '0;
            end else if (busy_q[p]) begin
              cnt_q[p] <= cnt_q[p] + 1'b1;
            end
          end
          STYLE_REPEAT: begin
            busy_q[p] <= 1'b0;
            if (!latch_q[p] || cnt_q[p] == PERIOD_LAST) begin
              cnt_q[p] <= '0;
            end else begin
              cnt_q[p] <= cnt_q[p] + 1'b1;
            end
          end
          default: begin
            busy_q[p] <= 1'b0;
            cnt_q[p]  <= '0;
          end
        endcase
      end
    end

    always_comb begin
      case (style[p])
        STYLE_ONE_PULSE: out_d[p] = busy_q[p];
        STYLE_REPEAT:    out_d[p] = latch_q[p] && (cnt_q[p] < PULSE_LEN);
        STYLE_LATCH:     out_d[p] = latch_q[p];
        default:         out_d[p] = cond[p];
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign o_reg_rdata     = rdata_q;
  assign o_irq_out_one   = out_q[0];
  assign o_irq_out_two   = out_q[1];
  assign o_irq_out_three = out_q[2];
  assign o_irq_out_four  = out_q[3];

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_latched_no_clear(int unsigned p);
    latch_q[p] && !i_sticky_cleared;
  endsequence

  a_route_one_reach: assert property (
    i_dsp_irq[0] && dsp_src_one_route_q == 3'h1 |-> cond[0])
    else $error("source one routed to pin one did not reach it");

  a_route_two_write: assert property (
    i_reg_wr && i_reg_addr == ADDR_ROUTE_A |=> dsp_src_two_route_q == $past(i_reg_wdata[2:0]))
    else $error("source two route not taken from low bits");

  a_route_three_write: assert property (
    i_reg_wr && i_reg_addr == ADDR_ROUTE_B |=> dsp_src_three_route_q == $past(i_reg_wdata[6:4]))
    else $error("source three route not taken from high bits");

  a_route_four_reach: assert property (
    i_dsp_irq[3] && dsp_src_four_route_q == 3'h4 |-> cond[3])
    else $error("source four routed to pin four did not reach it");

  a_style_one_write: assert property (
    i_reg_wr && i_reg_addr == ADDR_STYLE |=> pin_one_signal_style_q == style_t'($past(i_reg_wdata[7:6])))
    else $error("pin one style not taken from bits 7-6");

  a_pulse_start_zero: assert property (
    style[0] == STYLE_ONE_PULSE && evt[0] && !busy_q[0] |=> busy_q[0] && cnt_q[0] == '0 ##1 o_irq_out_one)
    else $error("single pulse did not start on pin one");

  a_pulse_end_exact: assert property (
    style[0] == STYLE_ONE_PULSE && busy_q[0] && cnt_q[0] == PULSE_LAST |=> !busy_q[0])
    else $error("single pulse did not end after its length");

  a_repeat_wrap: assert property (
    style[0] == STYLE_REPEAT && latch_q[0] && cnt_q[0] == PERIOD_LAST |=> cnt_q[0] == '0)
    else $error("repeat period did not wrap on pin one");

  a_latch_holds: assert property (
    s_latched_no_clear(2) |=> latch_q[2])
    else $error("latched interrupt dropped without a status clear");

  a_latch_clears: assert property (
    latch_q[2] && i_sticky_cleared && !evt[2] |=> !latch_q[2])
    else $error("latched interrupt not cleared by status read");

  a_latch_drives_pin: assert property (
    style[0] == STYLE_LATCH && latch_q[0] && $stable(style[0]) |=> o_irq_out_one)
    else $error("latched style did not hold pin one high");

  a_live_follows: assert property (
    style[3] == STYLE_LIVE && $stable(style[3]) |=> o_irq_out_four == $past(cond[3]))
    else $error("live style did not follow the condition");

  a_reserved_ignored: assert property (
    (route[0] == 3'h0 || route[0] > 3'h4) && (route[1] == 3'h0 || route[1] > 3'h4) &&
    (route[2] == 3'h0 || route[2] > 3'h4) && (route[3] == 3'h0 || route[3] > 3'h4) &&
    (route[4] == 3'h0 || route[4] > 3'h4) |-> cond == '0)
    else $error("reserved route code reached a pin");

  a_overtemp_reach: assert property (
    i_overtemp && overtemp_route_q == 3'h2 |-> cond[1])
    else $error("over-temperature routed to pin two did not reach it");

endmodule

// file: tb/irq_host_model.sv
module irq_host_model (
  input  wire logic       i_clk,            // Main clock.
  input  wire logic [3:0] i_pins,           // Interrupt pins, bit 0 is pin one.
  input  wire logic       i_zero,           // Clears the tallies.
  input  wire logic       i_read_status,    // Host reads both status registers.
  output logic            o_sticky_cleared, // Clear pulse toward the block.
  output logic [3:0][7:0] o_rises,          // Rising edges seen on each pin.
  output logic [3:0][7:0] o_highs           // High cycles seen on each pin.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] prev_q = 4'h0;
  logic       req_q  = 1'b0;
  initial begin
    o_sticky_cleared = 1'b0;
    o_rises          = '0;
    o_highs          = '0;
  end
  // The host tallies what each pin shows, as a pin watcher would.
  always @(posedge i_clk) begin
    req_q  <= i_read_status;
    prev_q <= i_pins;
    for (int p = 0; p < 4; p++) begin
      if (i_zero) begin
        o_rises[p] <= 8'h00;
        o_highs[p] <= 8'h00;
      end else begin
        o_rises[p] <= o_rises[p] + 8'(i_pins[p] & ~prev_q[p]);
        o_highs[p] <= o_highs[p] + 8'(i_pins[p]);
      end
    end
  end
  // Reading both status registers clears them; the block sees one pulse off the sampling edge.
  always @(negedge i_clk) o_sticky_cleared <= req_q;
endmodule

// file: tb/dsp_interrupt_routing_indication_tb.sv
module dsp_interrupt_routing_indication_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import irq_route_pkg::*;
  logic            i_clk = 1'b0;
  logic            i_rst, i_overtemp, i_reg_wr, i_reg_rd, zero, rd_stat, clr;
  logic      [3:0] i_dsp_irq, pins;
  logic      [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, exp_v;
  logic [3:0][7:0] rises, highs;
  int              n_errors = 0;
  int              samples_checked = 0;

  always #2 i_clk = ~i_clk;

  dsp_irq_router #(.PULSE_CYCLES(8), .PERIOD_CYCLES(16)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_dsp_irq(i_dsp_irq), .i_overtemp(i_overtemp),
    .i_sticky_cleared(clr), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
    .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_irq_out_one(pins[0]), .o_irq_out_two(pins[1]), .o_irq_out_three(pins[2]),
    .o_irq_out_four(pins[3]));

  irq_host_model host (
    .i_clk(i_clk), .i_pins(pins), .i_zero(zero), .i_read_status(rd_stat),
    .o_sticky_cleared(clr), .o_rises(rises), .o_highs(highs));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_wdata = v;
    i_reg_wr = 1'b1;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    chk("register read", o_reg_rdata, exp);
  endtask

  // Source 4 stands for the over-temperature event.
  task automatic route(input int s, input logic [2:0] r);
    if (s == 4) wr(ADDR_OT_ROUTE, {5'h00, r});
    else wr((s < 2) ? ADDR_ROUTE_A : ADDR_ROUTE_B, (s % 2 == 0) ? {1'b0, r, 4'h0} : {5'h00, r});
  endtask

  task automatic src(input int s, input logic v);
    if (s == 4) i_overtemp = v;
    else i_dsp_irq[s] = v;
  endtask

  task automatic pulse_src0_zero;
    @(negedge i_clk);
    zero = 1'b1;
    i_dsp_irq[0] = 1'b1;
    @(negedge i_clk);
    zero = 1'b0;
    i_dsp_irq[0] = 1'b0;
  endtask

  task automatic host_clear;
    rd_stat = 1'b1;
    wait_n(1);
    rd_stat = 1'b0;
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #20000;
    n_errors++;
    $display("watchdog expired before the tests ended");
    conclude();
  end

  initial begin
    {i_rst, i_overtemp, i_reg_wr, i_reg_rd, zero, rd_stat} = 6'b100000;
    {i_dsp_irq, i_reg_addr, i_reg_wdata} = 20'h00000;
    wait_n(2);
    i_rst = 1'b0;
    rd_chk(ADDR_ROUTE_A, 8'h00);
    rd_chk(ADDR_ROUTE_B, 8'h00);
    rd_chk(ADDR_STYLE, 8'h00);
    chk("pins after reset", {4'h0, pins}, 8'h00);
    wr(ADDR_ROUTE_A, 8'hFF);
    rd_chk(ADDR_ROUTE_A, 8'h77);
    wr(ADDR_ROUTE_B, 8'hFF);
    rd_chk(ADDR_ROUTE_B, 8'h77);
    wr(ADDR_STYLE, 8'hA5);
    rd_chk(ADDR_STYLE, 8'hA5);
    wr(8'h73, 8'hFF);
    rd_chk(8'h73, 8'h00);
    // Each source to each route code, with only the target pin in live style, or all pins for codes 0 and 5-7.
    for (int s = 0; s < 5; s++) begin
      for (int r = 0; r < 8; r++) begin
        exp_v = (r >= 1 && r <= 4) ? 8'(1 << (r - 1)) : 8'h00;
        wr(ADDR_STYLE, (r >= 1 && r <= 4) ? 8'(3 << (2 * (4 - r))) : 8'hFF);
        route((s + 1) % 5, 3'h0);
        route(s, 3'(r));
        src(s, 1'b1);
        wait_n(3);
        chk("pins while source high", {4'h0, pins}, exp_v);
        src(s, 1'b0);
        wait_n(3);
        chk("pins after source drop", {4'h0, pins}, 8'h00);
      end
    end
    route(4, 3'h0);
    route(0, 3'h1);
    wr(ADDR_STYLE, 8'h3F);
    @(negedge i_clk);
    zero = 1'b1;
    i_dsp_irq[0] = 1'b1;
    @(negedge i_clk);
    zero = 1'b0;
    wait_n(40);
    chk("single pulse count", rises[0], 8'h01);
    chk("single pulse width", highs[0], 8'h08);
    i_dsp_irq[0] = 1'b0;
    // The latch was set by earlier events on pin one; clear it so repeating starts with the new event.
    host_clear();
    wait_n(2);
    wr(ADDR_STYLE, 8'h7F);
    pulse_src0_zero();
    wait_n(63);
    chk("repeat pulse count", rises[0], 8'h04);
    chk("repeat high cycles", highs[0], 8'h20);
    host_clear();
    wait_n(20);
    zero = 1'b1;
    wait_n(1);
    zero = 1'b0;
    wait_n(40);
    chk("pulses after clear", rises[0], 8'h00);
    wr(ADDR_STYLE, 8'hBF);
    pulse_src0_zero();
    wait_n(30);
    chk("latched pin", {7'h00, pins[0]}, 8'h01);
    host_clear();
    wait_n(4);
    chk("latched pin after clear", {7'h00, pins[0]}, 8'h00);
    conclude();
  end
endmodule
